// ---- logic/octal_latch_pkg.sv ----
// Package for the octal inverting latch/register block.
// Assumes a single 50 MHz core clock; no software-visible registers.
package octal_latch_pkg;

  // ----------------------------------------------------------------
  // Widths, modes and reset values
  // ----------------------------------------------------------------
  localparam int          DATA_WIDTH = 8;
  localparam logic [7:0]  STORE_RESET = 8'h00;
  localparam logic [7:0]  OE_N_DRIVE  = 8'h00;
  localparam logic [7:0]  OE_N_FLOAT  = 8'hFF;
  localparam logic [1:0]  SYNC_RESET  = 2'h0;

  typedef logic [DATA_WIDTH-1:0] byte_t;

  // Variant select: transparent latch or edge register.
  typedef enum logic {
    MODE_LATCH,
    MODE_REGISTER
  } variant_e;

  // Storage controls that travel together.
  typedef struct packed {
    logic  latch_enable;
    logic  capture_clock;
  } store_ctrl_s;

  // Three-state output pin group (enable low while driving).
  typedef struct packed {
    byte_t out;
    byte_t oe_n;
  } pin_bus_s;

endpackage : octal_latch_pkg

// ---- logic/edge_detect.sv ----
// Rising and falling edge detector for one sampled control line.
// Assumes the input is synchronous to core_clk.
`timescale 1ns/1ps
module edge_detect
  import octal_latch_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_sync_n,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
  } state_s;

  state_s state;
  state_s next_state;

  // The previous level is the only memory; edges are combinational.
  always_comb begin
    next_state      = state;
    next_state.prev = level;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise = level & ~state.prev;
  assign fall = ~level & state.prev;

endmodule : edge_detect

// ---- logic/octal_inverting_latch_register.sv ----
// Octal storage element with inverting three-state outputs.
// Assumes all inputs are synchronous to core_clk and sampled each cycle;
// the three-state wire is resolved outside from out and oe_n.
`timescale 1ns/1ps

module octal_inverting_latch_register
  import octal_latch_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire variant_e    variant,
  input  wire store_ctrl_s store_ctrl,
  input  wire byte_t       data_inputs,
  input  wire logic        output_enable_n,
  output byte_t            inverted_outputs,
  output byte_t            inverted_outputs_oe_n,
  output byte_t            stored_value
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_sync_n;

  // Assertion is immediate; release waits two clocks to avoid metastable
  // recovery on the state flip-flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= SYNC_RESET;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // Capture clock edge
  // ----------------------------------------------------------------
  logic clk_rise;

  edge_detect u_clk_edge (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .level      (store_ctrl.capture_clock),
    .rise       (clk_rise),
    .fall       ()
  );

  // ----------------------------------------------------------------
  // Storage and output state
  // ----------------------------------------------------------------
  typedef struct packed {
    byte_t    store;
    pin_bus_s pins;
  } state_s;

  state_s state;
  state_s next_state;
  logic   load;
  byte_t  shown;

  // The latch is modelled as sampled transparency: while the enable is
  // high the store follows the inputs every cycle, so the last cycle with
  // the enable high holds the value seen just before the falling edge.
  // The trade-off is one cycle of latency from input to output.
  always_comb begin
    next_state = state;
    load       = 1'b0;
    case (variant)
      MODE_LATCH:    load = store_ctrl.latch_enable;
      MODE_REGISTER: load = clk_rise;
      default:       load = 1'b0;
    endcase
    // Storage ignores the output enable entirely.
    if (load) begin
      next_state.store = data_inputs;
    end
    // On any load (open latch or capture edge) the pins show the complement of the live input, else that of the store.
    shown = load ? data_inputs : state.store;
    next_state.pins.out = ~shown;
    if (output_enable_n) begin
      next_state.pins.oe_n = OE_N_FLOAT;
    end else begin
      next_state.pins.oe_n = OE_N_DRIVE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state.store     <= STORE_RESET;
      state.pins.out  <= ~STORE_RESET;
      state.pins.oe_n <= OE_N_FLOAT;
    end else begin
      state <= next_state;
    end
  end

  assign inverted_outputs      = state.pins.out;
  assign inverted_outputs_oe_n = state.pins.oe_n;
  assign stored_value          = state.store;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Named steps shared by the properties below. Each is sampled on the
  // same edge as the storage flops, so a step seen at one edge shows up
  // on the outputs at the next.
  sequence reg_edge_s;
    variant == MODE_REGISTER && clk_rise;
  endsequence

  sequence reg_idle_s;
    variant == MODE_REGISTER && !clk_rise;
  endsequence

  sequence latch_open_s;
    variant == MODE_LATCH && store_ctrl.latch_enable;
  endsequence

  // The previous sample must be out of reset, else the held value is the
  // reset value rather than the last enabled input.
  sequence latch_fall_s;
    variant == MODE_LATCH && $fell(store_ctrl.latch_enable) && $past(rst_sync_n);
  endsequence

  // Register variant: the store moves only on a detected capture edge.
  reg_only_edge_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    (variant == MODE_REGISTER && !clk_rise) |=> $stable(stored_value))
    else $error("register store changed without a clock edge");

  reg_capture_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    reg_edge_s |=> stored_value == $past(data_inputs))
    else $error("register did not capture the sampled input");

  reg_invert_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    reg_edge_s |=> inverted_outputs == ~$past(data_inputs))
    else $error("register output is not the complement of the input");

  reg_idle_out_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    reg_idle_s |=> $stable(inverted_outputs))
    else $error("register outputs changed without a clock edge");

  // Latch variant: transparent while enabled, frozen after the fall.
  latch_follow_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    (variant == MODE_LATCH && store_ctrl.latch_enable)
      |=> inverted_outputs == ~$past(data_inputs))
    else $error("transparent latch output does not follow input");

  latch_store_follow_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    latch_open_s |=> stored_value == $past(data_inputs))
    else $error("transparent latch store does not follow input");

  latch_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    latch_fall_s |=> stored_value == $past(data_inputs, 2))
    else $error("latch did not keep the last enabled input");

  latch_hold_out_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    latch_fall_s |=> inverted_outputs == ~$past(data_inputs, 2))
    else $error("latch output lost the held value");

  idle_stable_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    (variant == MODE_LATCH && !store_ctrl.latch_enable)[*2]
      |=> $stable(inverted_outputs))
    else $error("outputs changed while latch enable stayed low");

  // Output buffers: the enable steers the pins and nothing else.
  oe_drive_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    !output_enable_n |=> inverted_outputs_oe_n == OE_N_DRIVE)
    else $error("outputs not driven with enable low");

  reg_drive_data_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    reg_edge_s ##0 !output_enable_n
      |=> inverted_outputs_oe_n == OE_N_DRIVE && inverted_outputs == ~$past(data_inputs))
    else $error("register data not driven with enable low");

  latch_drive_data_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    latch_open_s ##0 !output_enable_n
      |=> inverted_outputs_oe_n == OE_N_DRIVE && inverted_outputs == ~$past(data_inputs))
    else $error("transparent data not driven with enable low");

  oe_float_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    output_enable_n |=> inverted_outputs_oe_n == OE_N_FLOAT)
    else $error("outputs not floating with enable high");

  oe_no_store_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    reg_idle_s ##0 $changed(output_enable_n) |=> $stable(stored_value))
    else $error("output enable disturbed the register store");

  // Storage keeps working behind floating outputs.
  store_while_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    reg_edge_s ##0 output_enable_n |=> stored_value == $past(data_inputs))
    else $error("register failed to load while outputs disabled");

  latch_while_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_sync_n)
    latch_open_s ##0 output_enable_n |=> stored_value == $past(data_inputs))
    else $error("latch stopped following while outputs disabled");

endmodule : octal_inverting_latch_register

// ---- tb/bus_model.sv ----
// Shared three-state bus seen at the block's inverting outputs.
// Assumes the block holds oe_n low on every bit it drives.
`timescale 1ns/1ps
module bus_model
  import octal_latch_pkg::*;
(
  input  wire logic     core_clk,
  input  wire pin_bus_s pins,
  output byte_t         bus
);
  byte_t last;

  // Released bits show the inverse of their last driven level, so a stale value cannot pass.
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DATA_WIDTH; i++) begin
      if (!pins.oe_n[i]) begin
        last[i] <= pins.out[i];
      end
    end
  end

  // Each bit follows its driver only while that driver is enabled.
  always_comb begin
    for (int i = 0; i < DATA_WIDTH; i++) begin
      bus[i] = pins.oe_n[i] ? ~last[i] : pins.out[i];
    end
  end
endmodule : bus_model

// ---- tb/test_octal_inverting_latch_register.sv ----
// Self-checking bench for the octal inverting latch/register.
// Assumes outputs settle at the clock edge that samples inputs, ready by the next falling edge.
`timescale 1ns/1ps
module test_octal_inverting_latch_register
  import octal_latch_pkg::*;
;
  typedef struct packed {
    byte_t st;
    logic  drv;
  } note_s;
  logic        core_clk;
  logic        rst_n;
  variant_e    variant;
  store_ctrl_s store_ctrl;
  byte_t       data_inputs;
  logic        output_enable_n;
  byte_t       q;
  byte_t       q_oe_n;
  byte_t       stored_value;
  byte_t       bus;
  note_s       notes[$];
  int          fails;
  int          n_tests;
  logic [31:0] seed;
  byte_t       st;
  logic        prev_cc;

  octal_inverting_latch_register u_dut (
    .core_clk              (core_clk),
    .rst_n                 (rst_n),
    .variant               (variant),
    .store_ctrl            (store_ctrl),
    .data_inputs           (data_inputs),
    .output_enable_n       (output_enable_n),
    .inverted_outputs      (q),
    .inverted_outputs_oe_n (q_oe_n),
    .stored_value          (stored_value)
  );
  bus_model u_bus (
    .core_clk (core_clk),
    .pins     ({q, q_oe_n}),
    .bus      (bus)
  );

  // Free-running 50 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input byte_t seen, input byte_t exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // One cycle of random stimulus; the reference store ignores the output enable.
  task automatic step(input logic [31:0] r);
    #1;
    store_ctrl      = r[9:8];
    data_inputs     = r[7:0];
    output_enable_n = r[12];
    if (variant == MODE_REGISTER ? (r[8] && !prev_cc) : r[9]) begin
      st = r[7:0];
    end
    prev_cc = r[8];
    @(posedge core_clk);
    notes.push_back('{st, !r[12]});
  endtask : step

  // Takes the oldest note once the outputs have settled after each edge.
  always @(negedge core_clk) begin : watch
    note_s n;
    if (notes.size() > 0) begin
      n = notes.pop_front();
      chk(stored_value, n.st);
      chk(q, ~n.st);
      if (n.drv) begin
        chk(q_oe_n, OE_N_DRIVE);
        chk(bus, ~n.st);
      end else begin
        chk(q_oe_n, OE_N_FLOAT);
      end
    end
  end

  // Both variants in turn, each after its own reset.
  initial begin
    rst_n = 1'b0;
    variant = MODE_LATCH;
    store_ctrl = '0;
    data_inputs = 8'h00;
    output_enable_n = 1'b1;
    fails = 0;
    n_tests = 0;
    seed = 32'h73955F7C;
    for (int v = 0; v < 2; v++) begin
      #1;
      rst_n = 1'b0;
      variant = variant_e'(v);
      store_ctrl = '0;
      st = STORE_RESET;
      prev_cc = 1'b0;
      repeat (12) @(posedge core_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 80; i++) begin
        seed = xs(seed);
        step(seed);
      end
      // Let the last note be checked before the next reset clears the store.
      repeat (2) @(posedge core_clk);
      $display("variant %0d test done", v);
    end
    repeat (2) @(posedge core_clk);
    close_out();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #50000;
    fails++;
    close_out();
  end
endmodule : test_octal_inverting_latch_register
